// ---- verilog/pcg_consts.svh ----
// Register map, field positions and reset values of the CRC generator
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH

// Byte offsets of the word registers
`define PCG_OFF_CTRL1      8'h00
`define PCG_OFF_CTRL2      8'h04
`define PCG_OFF_TAPS_HIGH  8'h08
`define PCG_OFF_TAPS_LOW   8'h0C
`define PCG_OFF_DATA_IN    8'h10
`define PCG_OFF_RESULT     8'h14

// Control one field positions
`define PCG_C1_ENABLE      15
`define PCG_C1_STOP_IDLE   13
`define PCG_C1_COUNT_HI    12
`define PCG_C1_COUNT_LO    8
`define PCG_C1_FULL        7
`define PCG_C1_EMPTY       6
`define PCG_C1_INT_SEL     5
`define PCG_C1_START       4
`define PCG_C1_LSB_FIRST   3

// Control two field positions
`define PCG_C2_DWIDTH_HI   12
`define PCG_C2_DWIDTH_LO   8
`define PCG_C2_PLEN_HI     4
`define PCG_C2_PLEN_LO     0

// Reset values and FIFO limits
`define PCG_RST_HALF       16'h0000
`define PCG_RST_WORD       32'h0000_0000
`define PCG_FIFO_DEEP      5'h10
`define PCG_FIFO_SHALLOW   5'h08
`define PCG_PLEN_SHALLOW   5'h07

`endif

// ---- verilog/pcg_pkg.sv ----
// Types shared by the CRC generator
`default_nettype none
package pcg_pkg;

  // Software-writable bits of control one
  typedef struct packed {
    logic enable;
    logic stop_in_idle;
    logic interrupt_select;
    logic shifter_start;
    logic shift_order_lsb_first;
  } pcg_ctrl_t;

  // Polynomial and word shape from control two
  typedef struct packed {
    logic [4:0] data_width_field;
    logic [4:0] poly_length_field;
  } pcg_shape_t;

  // Shift engine states
  typedef enum logic [0:0] {
    PCG_IDLE,
    PCG_SHIFT
  } pcg_eng_t;

endpackage
`default_nettype wire

// ---- verilog/pcg_top.sv ----
// Programmable CRC generator with data FIFO and AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "pcg_consts.svh"

module pcg_top #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        device_idle,
  output logic             crc_irq
);

  localparam int PW = $clog2(FIFO_DEPTH);

  pcg_pkg::pcg_ctrl_t  ctrl_ff;
  pcg_pkg::pcg_shape_t shape_ff;
  pcg_pkg::pcg_eng_t   state_ff;
  logic [15:0]         taps_high_ff;
  logic [15:1]         taps_low_ff;
  logic [31:0]         data_in_ff;
  logic [31:0]         result_ff;
  logic [31:0]         fifo_mem [FIFO_DEPTH];
  logic [PW-1:0]       wr_ptr_ff;
  logic [PW-1:0]       rd_ptr_ff;
  logic [4:0]          count_ff;
  logic [31:0]         word_ff;
  logic [4:0]          bitcnt_ff;
  logic                wr_pend_ff;
  logic                rd_wait_ff;
  logic [7:0]          addr_ff;
  logic [31:0]         hrdata_ff;
  logic                irq_ff;
  logic [4:0]          fifo_max;
  logic                fifo_full;
  logic                fifo_empty;
  logic                run;
  logic                push;
  logic                pop;
  logic                last_bit;
  logic                din_bit;
  logic [31:0]         taps;
  logic [31:0]         nxt_result;
  logic                addr_take;
  logic [5:0]          reg_hit;

  // Register select from a byte offset
  function automatic logic [5:0] reg_sel(input logic [7:0] a);
    reg_sel = 6'h00;
    unique case (a)
      `PCG_OFF_CTRL1:     reg_sel[0] = 1'b1;
      `PCG_OFF_CTRL2:     reg_sel[1] = 1'b1;
      `PCG_OFF_TAPS_HIGH: reg_sel[2] = 1'b1;
      `PCG_OFF_TAPS_LOW:  reg_sel[3] = 1'b1;
      `PCG_OFF_DATA_IN:   reg_sel[4] = 1'b1;
      `PCG_OFF_RESULT:    reg_sel[5] = 1'b1;
      default:            reg_sel = 6'h00;
    endcase
  endfunction

  // One LFSR step of order plen+1
  function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic d,
                                           input logic [4:0] plen, input logic [31:0] tp);
    logic        fb;
    logic [31:0] n;
    fb = d ^ crc[plen];
    n  = 32'h0000_0000;
    for (int i = 1; i < 32; i++) begin
      n[i] = crc[i-1] ^ (tp[i] & fb);
    end
    n[0] = fb;
    crc_step = n & (32'hFFFF_FFFF >> (5'd31 - plen));
  endfunction

  // Bus handshake: reads take one wait state, writes none
  assign addr_take = hsel & hready & htrans[1];
  assign hreadyout = ~rd_wait_ff;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;
  assign reg_hit   = reg_sel(addr_ff);  // One-hot register hit of the data phase

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_wait_ff <= 1'b0;
      addr_ff    <= 8'h00;
    end else begin
      wr_pend_ff <= addr_take & hwrite;
      rd_wait_ff <= addr_take & ~hwrite;
      if (addr_take) begin
        addr_ff <= {haddr[7:2], 2'b00};
      end
    end
  end

  // Derived FIFO and engine conditions
  assign fifo_max   = (shape_ff.poly_length_field > `PCG_PLEN_SHALLOW) ?
                      `PCG_FIFO_SHALLOW : `PCG_FIFO_DEEP;
  assign fifo_full  = (count_ff == fifo_max);
  assign fifo_empty = (count_ff == 5'h00);
  assign run        = ctrl_ff.enable & ~(ctrl_ff.stop_in_idle & device_idle);
  assign push       = wr_pend_ff & reg_hit[4] & ctrl_ff.enable & ~fifo_full;
  assign pop        = run & ctrl_ff.shifter_start & (state_ff == pcg_pkg::PCG_IDLE) &
                      ~fifo_empty;
  assign last_bit   = (bitcnt_ff == shape_ff.data_width_field);
  assign din_bit    = ctrl_ff.shift_order_lsb_first ? word_ff[bitcnt_ff] :
                      word_ff[shape_ff.data_width_field - bitcnt_ff];
  assign taps       = {taps_high_ff, taps_low_ff, 1'b0};
  assign nxt_result = crc_step(result_ff, din_bit, shape_ff.poly_length_field, taps);

  // Configuration registers, kept through disable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff      <= '0;
      shape_ff     <= '0;
      taps_high_ff <= `PCG_RST_HALF;
      taps_low_ff  <= 15'h0000;
    end else if (wr_pend_ff) begin
      if (reg_hit[0]) begin
        ctrl_ff.enable                <= hwdata[`PCG_C1_ENABLE];
        ctrl_ff.stop_in_idle          <= hwdata[`PCG_C1_STOP_IDLE];
        ctrl_ff.interrupt_select      <= hwdata[`PCG_C1_INT_SEL];
        ctrl_ff.shifter_start         <= hwdata[`PCG_C1_START];
        ctrl_ff.shift_order_lsb_first <= hwdata[`PCG_C1_LSB_FIRST];
      end
      if (reg_hit[1]) begin
        shape_ff.data_width_field  <= hwdata[`PCG_C2_DWIDTH_HI:`PCG_C2_DWIDTH_LO];
        shape_ff.poly_length_field <= hwdata[`PCG_C2_PLEN_HI:`PCG_C2_PLEN_LO];
      end
      if (reg_hit[2]) begin
        taps_high_ff <= hwdata[15:0];
      end
      if (reg_hit[3]) begin
        taps_low_ff <= hwdata[15:1];
      end
    end
  end

  // Last accepted data word, cleared by disable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_in_ff <= `PCG_RST_WORD;
    end else if (!ctrl_ff.enable) begin
      data_in_ff <= `PCG_RST_WORD;
    end else if (push) begin
      data_in_ff <= hwdata;
    end
  end

  // FIFO storage
  always_ff @(posedge hclk) begin
    if (push) begin
      fifo_mem[wr_ptr_ff] <= hwdata;
    end
  end

  // FIFO pointers and valid word count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= 5'h00;
    end else if (!ctrl_ff.enable) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= 5'h00;
    end else begin
      if (push) begin
        wr_ptr_ff <= PW'(wr_ptr_ff + 1'b1);
      end
      if (pop) begin
        rd_ptr_ff <= PW'(rd_ptr_ff + 1'b1);
      end
      count_ff <= 5'(count_ff + {4'h0, push} - {4'h0, pop});
    end
  end

  // Shift engine: load a word, then one bit per clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff  <= pcg_pkg::PCG_IDLE;
      word_ff   <= `PCG_RST_WORD;
      bitcnt_ff <= 5'h00;
      result_ff <= `PCG_RST_WORD;
    end else if (!ctrl_ff.enable) begin
      state_ff  <= pcg_pkg::PCG_IDLE;
      word_ff   <= `PCG_RST_WORD;
      bitcnt_ff <= 5'h00;
      result_ff <= `PCG_RST_WORD;
    end else if (run) begin
      unique case (state_ff)
        pcg_pkg::PCG_IDLE: begin
          if (pop) begin
            word_ff   <= fifo_mem[rd_ptr_ff];
            bitcnt_ff <= 5'h00;
            state_ff  <= pcg_pkg::PCG_SHIFT;
          end
        end
        pcg_pkg::PCG_SHIFT: begin
          result_ff <= nxt_result;
          bitcnt_ff <= 5'(bitcnt_ff + 1'b1);
          if (last_bit) begin
            state_ff <= pcg_pkg::PCG_IDLE;
          end
        end
      endcase
    end
  end

  // Interrupt pulse on FIFO drained or on shift complete with the FIFO empty
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ff <= 1'b0;
    end else if (ctrl_ff.interrupt_select) begin
      irq_ff <= pop & ~push & (count_ff == 5'h01);
    end else begin
      irq_ff <= run & (state_ff == pcg_pkg::PCG_SHIFT) & last_bit & fifo_empty;
    end
  end
  assign crc_irq = irq_ff;

  // Read data, loaded in the wait state after the registers settle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= `PCG_RST_WORD;
    end else if (rd_wait_ff) begin
      hrdata_ff <= `PCG_RST_WORD;
      unique case (1'b1)
        reg_hit[0]: begin
          hrdata_ff[`PCG_C1_ENABLE]                    <= ctrl_ff.enable;
          hrdata_ff[`PCG_C1_STOP_IDLE]                 <= ctrl_ff.stop_in_idle;
          hrdata_ff[`PCG_C1_COUNT_HI:`PCG_C1_COUNT_LO] <= count_ff;
          hrdata_ff[`PCG_C1_FULL]                      <= fifo_full;
          hrdata_ff[`PCG_C1_EMPTY]                     <= fifo_empty;
          hrdata_ff[`PCG_C1_INT_SEL]                   <= ctrl_ff.interrupt_select;
          hrdata_ff[`PCG_C1_START]                     <= ctrl_ff.shifter_start;
          hrdata_ff[`PCG_C1_LSB_FIRST]                 <= ctrl_ff.shift_order_lsb_first;
        end
        reg_hit[1]: begin
          hrdata_ff[`PCG_C2_DWIDTH_HI:`PCG_C2_DWIDTH_LO] <= shape_ff.data_width_field;
          hrdata_ff[`PCG_C2_PLEN_HI:`PCG_C2_PLEN_LO]     <= shape_ff.poly_length_field;
        end
        reg_hit[2]: hrdata_ff[15:0] <= taps_high_ff;
        reg_hit[3]: hrdata_ff[15:1] <= taps_low_ff;
        reg_hit[4]: hrdata_ff       <= data_in_ff;
        reg_hit[5]: hrdata_ff       <= result_ff;
        default:    hrdata_ff       <= `PCG_RST_WORD;
      endcase
    end
  end

  // Checks on the engine and FIFO
  chk_disable_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_ff.enable |=> count_ff == 5'h00 && result_ff == 32'h0000_0000 &&
      state_ff == pcg_pkg::PCG_IDLE)
    else $error("disable did not clear engine state");

  chk_count_limit: assert property (@(posedge hclk) disable iff (!hresetn)
    count_ff <= fifo_max)
    else $error("word count above FIFO limit");

  chk_full_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    fifo_full == (count_ff == ((shape_ff.poly_length_field > 5'h07) ? 5'h08 : 5'h10)))
    else $error("full flag does not match count");

  chk_full_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_ff && reg_hit[4] && fifo_full && !pop && ctrl_ff.enable
      && $stable(ctrl_ff) |=> count_ff == $past(count_ff))
    else $error("write while full changed the count");

  chk_start_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_ff.shifter_start && state_ff == pcg_pkg::PCG_IDLE
      |=> state_ff == pcg_pkg::PCG_IDLE)
    else $error("shifter ran with start clear");

  chk_word_length: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(state_ff == pcg_pkg::PCG_SHIFT) && shape_ff.data_width_field == 5'h03
      && ctrl_ff.enable && !ctrl_ff.stop_in_idle && $stable(shape_ff)
      |-> (state_ff == pcg_pkg::PCG_SHIFT)[*4] ##1 state_ff == pcg_pkg::PCG_IDLE)
    else $error("four-bit word not shifted in four clocks");

  chk_idle_halt: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_ff.enable && ctrl_ff.stop_in_idle && device_idle
      |=> $stable(result_ff) && $stable(bitcnt_ff))
    else $error("engine advanced while halted in idle");

  chk_irq_empty: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_ff.interrupt_select && pop && count_ff == 5'h01 && !push
      |=> crc_irq && fifo_empty)
    else $error("no interrupt when FIFO drained");

  chk_irq_done: assert property (@(posedge hclk) disable iff (!hresetn)
    crc_irq && !$past(ctrl_ff.interrupt_select)
      |-> $past(state_ff) == pcg_pkg::PCG_SHIFT && state_ff == pcg_pkg::PCG_IDLE)
    else $error("shift-done interrupt without finished shift");

  chk_empty_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    pop && count_ff == 5'h01 && !push |=> fifo_empty)
    else $error("empty flag not set after last pop");

  cov_full_fifo: cover property (@(posedge hclk) disable iff (!hresetn) fifo_full);
  cov_irq_done: cover property (@(posedge hclk) disable iff (!hresetn)
    crc_irq && !ctrl_ff.interrupt_select);
  cov_irq_empty: cover property (@(posedge hclk) disable iff (!hresetn)
    crc_irq && ctrl_ff.interrupt_select);

endmodule
`default_nettype wire

// ---- tb/pcg_top_tb.sv ----
// Self-checking testbench for the programmable CRC generator
`timescale 1ns/10ps
`default_nettype none
`include "pcg_consts.svh"

module pcg_top_tb;
  logic        hclk        = 1'b0;
  logic        hresetn     = 1'b0;
  logic        hsel        = 1'b0;
  logic [31:0] haddr       = 32'h0000_0000;
  logic [1:0]  htrans      = 2'h0;
  logic        hwrite      = 1'b0;
  logic [2:0]  hsize       = 3'h2;
  logic [31:0] hwdata      = 32'h0000_0000;
  logic        device_idle = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        crc_irq;
  logic        rdy_s;
  logic [31:0] rd_s;
  logic        resp_s;
  int          err_count   = 0;
  int          n_checks    = 0;
  int          cyc         = 0;
  int          n_a;
  int          n_b;

  // Clock of 4 ns period
  always #2 hclk = ~hclk;

  pcg_top #(.FIFO_DEPTH(16)) i_pcg_top (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .hsel        (hsel),
    .haddr       (haddr),
    .htrans      (htrans),
    .hwrite      (hwrite),
    .hsize       (hsize),
    .hwdata      (hwdata),
    .hready      (hreadyout),
    .hrdata      (hrdata),
    .hreadyout   (hreadyout),
    .hresp       (hresp),
    .device_idle (device_idle),
    .crc_irq     (crc_irq)
  );

  // Settled copies of slave outputs, taken mid-cycle
  always @(negedge hclk) begin
    rdy_s = hreadyout;
    rd_s  = hrdata;
    resp_s = hresp;
  end

  // Run limit against hangs
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Single word write: address phase, then data phase
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    @(posedge hclk);
    while (rdy_s !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (rdy_s !== 1'b1) @(posedge hclk);
  endtask

  // Single word read compared against an expected value
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    @(posedge hclk);
    while (rdy_s !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    @(posedge hclk);
    while (rdy_s !== 1'b1) @(posedge hclk);
    chk(what, exp, rd_s);
    chk("response code", 32'h0, {31'h0, resp_s});
  endtask

  // Bounded wait for the interrupt pulse, counting cycles
  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (crc_irq !== 1'b1 && n < 200);
    @(posedge hclk);
  endtask

  // Bit-serial reference of the shift engine
  function automatic logic [31:0] crc_ref(input logic [31:0] seed, input logic [31:0] w,
                                          input int dw, input int pl, input logic [31:0] taps,
                                          input logic lsb);
    logic [31:0] r;
    logic        fb;
    r = seed;
    for (int i = 0; i <= dw; i++) begin
      fb = (lsb ? w[i] : w[dw - i]) ^ r[pl];
      r  = {r[30:0], fb} ^ ({32{fb}} & taps & 32'hFFFF_FFFE);
      if (pl < 31) r = r & ((32'h1 << (pl + 1)) - 32'h1);
    end
    return r;
  endfunction

  // One checksum run: set up, fill, start, compare result and flags
  task automatic run_crc(input logic [31:0] c2, input logic [31:0] taps, input logic [31:0] c1,
                         input int nw, input logic [31:0] w0, input logic [31:0] w1,
                         output int n);
    logic [31:0] r;
    r = crc_ref(32'h0, w0, int'(c2[12:8]), int'(c2[4:0]), taps, c1[3]);
    if (nw == 2) r = crc_ref(r, w1, int'(c2[12:8]), int'(c2[4:0]), taps, c1[3]);
    bus_write(`PCG_OFF_CTRL2, c2);
    bus_write(`PCG_OFF_TAPS_HIGH, {16'h0000, taps[31:16]});
    bus_write(`PCG_OFF_TAPS_LOW, {16'h0000, taps[15:0]});
    bus_write(`PCG_OFF_CTRL1, c1);
    bus_write(`PCG_OFF_DATA_IN, w0);
    if (nw == 2) bus_write(`PCG_OFF_DATA_IN, w1);
    repeat (10) @(posedge hclk);
    rd_chk(`PCG_OFF_CTRL1, c1 | (32'(nw) << 8), "count before start");
    bus_write(`PCG_OFF_CTRL1, c1 | 32'h0000_0010);
    wait_irq(n);
    chk("interrupt seen", 32'h1, {31'h0, n < 200});
    repeat (40) @(posedge hclk);
    rd_chk(`PCG_OFF_RESULT, r, "result word");
    rd_chk(`PCG_OFF_CTRL1, c1 | 32'h0000_0050, "flags after run");
    bus_write(`PCG_OFF_CTRL1, 32'h0);
    rd_chk(`PCG_OFF_RESULT, 32'h0, "result after disable");
  endtask

  // Reset values, unmapped place and unimplemented bits
  task automatic t_regs();
    rd_chk(`PCG_OFF_CTRL1, 32'h0000_0040, "control one reset");
    rd_chk(`PCG_OFF_CTRL2, 32'h0, "control two reset");
    rd_chk(8'h1C, 32'h0, "unmapped read");
    bus_write(`PCG_OFF_CTRL2, 32'hFFFF_FFFF);
    rd_chk(`PCG_OFF_CTRL2, 32'h0000_1F1F, "control two bits");
    bus_write(`PCG_OFF_TAPS_HIGH, 32'hFFFF_FFFF);
    rd_chk(`PCG_OFF_TAPS_HIGH, 32'h0000_FFFF, "taps high bits");
    bus_write(`PCG_OFF_TAPS_LOW, 32'hFFFF_FFFF);
    rd_chk(`PCG_OFF_TAPS_LOW, 32'h0000_FFFE, "taps low bits");
    bus_write(`PCG_OFF_CTRL1, 32'hFFFF_FFFF);
    rd_chk(`PCG_OFF_CTRL1, 32'h0000_A078, "control one bits");
    bus_write(`PCG_OFF_CTRL1, 32'h0);
  endtask

  // Occupancy, limits, drops while full or disabled, disable clearing
  task automatic t_fifo();
    logic [31:0] cnt;
    bus_write(`PCG_OFF_CTRL2, 32'h0000_0F0F);
    bus_write(`PCG_OFF_DATA_IN, 32'h0000_00AA);
    rd_chk(`PCG_OFF_CTRL1, 32'h0000_0040, "write while disabled");
    bus_write(`PCG_OFF_CTRL1, 32'h0000_8000);
    for (int i = 0; i < 9; i++) begin
      bus_write(`PCG_OFF_DATA_IN, 32'h0000_0100 + 32'(i));
      cnt = (i < 8) ? 32'(i + 1) : 32'h8;
      rd_chk(`PCG_OFF_CTRL1, 32'h8000 | (cnt << 8) | ((cnt == 8) ? 32'h80 : 32'h0),
             "count at plen 15");
    end
    rd_chk(`PCG_OFF_DATA_IN, 32'h0000_0107, "last accepted word");
    bus_write(`PCG_OFF_CTRL2, 32'h0000_0F07);
    rd_chk(`PCG_OFF_CTRL1, 32'h0000_8800, "deeper limit");
    for (int i = 0; i < 8; i++) bus_write(`PCG_OFF_DATA_IN, 32'(i));
    rd_chk(`PCG_OFF_CTRL1, 32'h0000_9080, "full at plen 7");
    bus_write(`PCG_OFF_CTRL1, 32'h0);
    rd_chk(`PCG_OFF_CTRL1, 32'h0000_0040, "cleared by disable");
    rd_chk(`PCG_OFF_CTRL2, 32'h0000_0F07, "config kept");
    rd_chk(`PCG_OFF_DATA_IN, 32'h0, "data word cleared");
  endtask

  // Stop in idle halts popping until idle ends
  task automatic t_idle();
    int n;
    bus_write(`PCG_OFF_CTRL2, 32'h0000_0707);
    bus_write(`PCG_OFF_CTRL1, 32'h0000_A000);
    device_idle <= 1'b1;
    bus_write(`PCG_OFF_DATA_IN, 32'h0000_00C3);
    bus_write(`PCG_OFF_CTRL1, 32'h0000_A010);
    repeat (30) @(posedge hclk);
    rd_chk(`PCG_OFF_CTRL1, 32'h0000_A110, "halted in idle");
    device_idle <= 1'b0;
    wait_irq(n);
    chk("runs after idle", 32'h1, {31'h0, n < 200});
    bus_write(`PCG_OFF_CTRL1, 32'h0);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_fifo();
    device_idle <= 1'b1;
    run_crc(32'h0000_070F, 32'h0000_1020, 32'h0000_8000, 2, 32'h31, 32'h32, n_a);
    device_idle <= 1'b0;
    run_crc(32'h0000_1F1F, 32'h04C1_1DB6, 32'h0000_8008, 1, 32'h1234_5678, 32'h0, n_a);
    run_crc(32'h0000_030F, 32'h0000_1020, 32'h0000_8008, 2, 32'h15, 32'h0A, n_a);
    run_crc(32'h0000_0704, 32'h0000_0004, 32'h0000_8000, 1, 32'h5A, 32'h0, n_a);
    run_crc(32'h0000_0704, 32'h0000_0004, 32'h0000_8020, 1, 32'h5A, 32'h0, n_b);
    chk("interrupt lead", 32'h8, 32'(n_a - n_b));
    t_idle();
    give_verdict();
  end
endmodule

`default_nettype wire
